/* rtl/dsm_ctrl.sv */
// Speed-mode control of a motor drive with an APB register file
// Assumes an APB master on pclk; power stage samples the motor outputs
`timescale 1ns/10ps
`include "dsm_defs.svh"
module dsm_ctrl #(
  parameter int EXC_CYC  = `DSM_EXC_CYC,
  parameter int TICK_CYC = `DSM_TICK_CYC
) (
  input  wire logic             pclk,         // APB clock
  input  wire logic             presetn,      // Async reset, active low
  input  wire logic             psel,         // APB select
  input  wire logic             penable,      // APB access phase
  input  wire logic             pwrite,       // APB write
  input  wire logic [7:0]       paddr,        // APB byte address
  input  wire dsm_pkg::dsm_data_t pwdata,     // APB write data
  output dsm_pkg::dsm_data_t    prdata,       // APB read data
  output logic                  pready,       // APB ready
  output logic                  pslverr,      // APB error on unmapped address
  output logic                  motor_enable, // Power stage energised
  output logic                  motor_reverse,// Reverse rotation
  output dsm_pkg::dsm_word_t    motor_speed_command    // Frequency command, 0.01 Hz
);
  import dsm_pkg::*;

  logic      run_at_set_frequency;
  logic      reverse_direction;
  logic      excite_power;
  logic      quick_stop_request;
  logic      halt_request;
  logic      frequency_lock;
  dsm_word_t mode_select_word;
  dsm_word_t active_mode_word;
  dsm_word_t target_word;
  dsm_word_t accel_word;
  dsm_word_t decel_word;
  dsm_exc_e  exc_state;
  logic [31:0] exc_cnt;
  logic      excited_ready_status;
  logic      quick_stopping_status;
  logic      speed_command_attained;
  dsm_word_t output_frequency_word;
  dsm_word_t goal;
  logic [31:0] period;
  logic      hold;
  logic      zero_now;
  logic      speed_mode;
  logic      setup;
  logic      wr;
  logic      hit;

  // Elaboration-time parameter checks
  if (EXC_CYC < 1) begin : g_exc_cyc_check
    $error("dsm_ctrl: EXC_CYC must be at least 1");
  end
  if (TICK_CYC < 1) begin : g_tick_cyc_check
    $error("dsm_ctrl: TICK_CYC must be at least 1");
  end

  function automatic logic known(input logic [7:0] a);
    case (a)
      `DSM_CTRL_OFS, `DSM_MODE_OFS, `DSM_TARGET_OFS, `DSM_ACCEL_OFS,
      `DSM_DECEL_OFS, `DSM_STATUS_OFS, `DSM_OUTFREQ_OFS,
      `DSM_ACTMODE_OFS: known = 1'b1;
      default: known = 1'b0;
    endcase
  endfunction

  // Write access to one register in this cycle
  function automatic logic wr_to(input logic [7:0] ofs);
    wr_to = wr && (paddr == ofs);
  endfunction

  // Control bits as they read back
  function automatic dsm_data_t ctrl_image();
    dsm_data_t v;
    v = 32'h0000_0000;
    v[`DSM_RUN_BIT]  = run_at_set_frequency;
    v[`DSM_REV_BIT]  = reverse_direction;
    v[`DSM_EXC_BIT]  = excite_power;
    v[`DSM_QS_BIT]   = quick_stop_request;
    v[`DSM_HALT_BIT] = halt_request;
    v[`DSM_LOCK_BIT] = frequency_lock;
    ctrl_image = v;
  endfunction

  // Status bits as they read back
  function automatic dsm_data_t status_image();
    dsm_data_t v;
    v = 32'h0000_0000;
    v[`DSM_ST_ATT_BIT] = speed_command_attained;
    v[`DSM_ST_RDY_BIT] = excited_ready_status;
    v[`DSM_ST_QS_BIT]  = quick_stopping_status;
    status_image = v;
  endfunction

  // Ramp time word to cycles between steps, minus one
  function automatic logic [31:0] to_period(input dsm_word_t t);
    logic [47:0] p;
    p = 48'(t) * 48'(TICK_CYC);
    if (p == 48'h0) begin
      to_period = 32'h0000_0000;
    end else if (p[47:32] != 16'h0) begin
      to_period = 32'hFFFF_FFFF;
    end else begin
      to_period = p[31:0] - 32'h0000_0001;
    end
  endfunction

  function automatic dsm_word_t clamp(input dsm_word_t f);
    clamp = (f > `DSM_SPEED_COMMAND_MAX) ? `DSM_SPEED_COMMAND_MAX : f;
  endfunction

  // APB handshake: zero wait states, answer in the access cycle
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit <= 1'b1;
    end else if (setup) begin
      hit <= known(paddr);
    end
  end

  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `DSM_CTRL_OFS:    prdata <= ctrl_image();
        `DSM_MODE_OFS:    prdata <= {16'h0000, mode_select_word};
        `DSM_TARGET_OFS:  prdata <= {16'h0000, target_word};
        `DSM_ACCEL_OFS:   prdata <= {16'h0000, accel_word};
        `DSM_DECEL_OFS:   prdata <= {16'h0000, decel_word};
        `DSM_STATUS_OFS:  prdata <= status_image();
        `DSM_OUTFREQ_OFS: prdata <= {16'h0000, output_frequency_word};
        `DSM_ACTMODE_OFS: prdata <= {16'h0000, active_mode_word};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_at_set_frequency <= 1'b0;
      reverse_direction    <= 1'b0;
      excite_power         <= 1'b0;
      quick_stop_request   <= 1'b0;
      halt_request         <= 1'b0;
      frequency_lock       <= 1'b0;
    end else if (wr_to(`DSM_CTRL_OFS)) begin
      run_at_set_frequency <= pwdata[`DSM_RUN_BIT];
      reverse_direction    <= pwdata[`DSM_REV_BIT];
      excite_power         <= pwdata[`DSM_EXC_BIT];
      quick_stop_request   <= pwdata[`DSM_QS_BIT];
      halt_request         <= pwdata[`DSM_HALT_BIT];
      frequency_lock       <= pwdata[`DSM_LOCK_BIT];
    end
  end

  // Mode select word, speed mode after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_select_word <= `DSM_MODE_SPEED;
    end else if (wr_to(`DSM_MODE_OFS)) begin
      mode_select_word <= pwdata[15:0];
    end
  end

  // Mode in effect follows the select word one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_mode_word <= `DSM_MODE_SPEED;
    end else begin
      active_mode_word <= mode_select_word;
    end
  end

  assign speed_mode = (active_mode_word == `DSM_MODE_SPEED);

  // Speed command target, clamped to the output range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_word <= 16'h0000;
    end else if (wr_to(`DSM_TARGET_OFS)) begin
      target_word <= clamp(pwdata[15:0]);
    end
  end

  // Speed command acceleration time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accel_word <= `DSM_ACCEL_RST;
    end else if (wr_to(`DSM_ACCEL_OFS)) begin
      accel_word <= pwdata[15:0];
    end
  end

  // Speed command deceleration time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decel_word <= `DSM_DECEL_RST;
    end else if (wr_to(`DSM_DECEL_OFS)) begin
      decel_word <= pwdata[15:0];
    end
  end

  // Excitation sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_state <= DSM_OFF;
      exc_cnt   <= 32'h0000_0000;
    end else begin
      case (exc_state)
        DSM_OFF: begin
          exc_cnt <= 32'h0000_0000;
          if (excite_power) begin
            exc_state <= DSM_EXCITING;
          end
        end
        DSM_EXCITING: begin
          if (!excite_power) begin
            exc_state <= DSM_OFF;
          end else if (exc_cnt >= 32'(EXC_CYC - 1)) begin
            exc_state <= DSM_READY;
          end else begin
            exc_cnt <= exc_cnt + 32'h0000_0001;
          end
        end
        DSM_READY: begin
          if (!excite_power) begin
            exc_state <= DSM_OFF;
          end
        end
        default: exc_state <= DSM_OFF;
      endcase
    end
  end

  assign excited_ready_status = (exc_state == DSM_READY);

  // Request priority: excite, speed mode, quick stop, halt, lock, run
  always_comb begin
    goal     = 16'h0000;
    period   = to_period(decel_word);
    hold     = 1'b0;
    zero_now = 1'b0;
    if (!excite_power || !excited_ready_status) begin
      zero_now = 1'b1;
    end else if (!speed_mode) begin
      period = to_period(decel_word);
    end else if (quick_stop_request) begin
      period = `DSM_QS_PERIOD;
    end else if (halt_request) begin
      period = to_period(decel_word);
    end else if (frequency_lock) begin
      hold = 1'b1;
    end else if (run_at_set_frequency) begin
      goal = target_word;
      if (target_word > output_frequency_word) begin
        period = to_period(accel_word);
      end else begin
        period = to_period(decel_word);
      end
    end else begin
      period = to_period(decel_word);
    end
  end

  dsm_ramp #(
    .W (16)
  ) u_ramp (
    .pclk     (pclk),
    .presetn  (presetn),
    .goal     (goal),
    .period   (period),
    .hold     (hold),
    .zero_now (zero_now),
    .speed_command     (output_frequency_word)
  );

  // Frequency attained, only while running in speed mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_command_attained <= 1'b0;
    end else begin
      speed_command_attained <= run_at_set_frequency && excited_ready_status && speed_mode
                       && !quick_stop_request && !halt_request
                       && (output_frequency_word == target_word);
    end
  end

  // Quick stopping while quick stop is requested and the frequency is not zero, in any mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quick_stopping_status <= 1'b0;
    end else begin
      quick_stopping_status <= excited_ready_status && quick_stop_request
                               && (output_frequency_word != 16'h0000);
    end
  end

  // Power stage energised from the start of excitation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_enable <= 1'b0;
    end else begin
      motor_enable <= (exc_state != DSM_OFF);
    end
  end

  // Rotation sense to the power stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_reverse <= 1'b0;
    end else begin
      motor_reverse <= reverse_direction;
    end
  end

  // Frequency command, one cycle behind the ramp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_speed_command <= 16'h0000;
    end else begin
      motor_speed_command <= output_frequency_word;
    end
  end
endmodule

/* rtl/dsm_defs.svh */
// Register map, field positions, reset values and timing for speed-mode control
// Included by the design modules dsm_ctrl and dsm_ramp
`ifndef DSM_DEFS_SVH
`define DSM_DEFS_SVH
`define DSM_CTRL_OFS      8'h00
`define DSM_MODE_OFS      8'h04
`define DSM_TARGET_OFS    8'h08
`define DSM_ACCEL_OFS     8'h0C
`define DSM_DECEL_OFS     8'h10
`define DSM_STATUS_OFS    8'h14
`define DSM_OUTFREQ_OFS   8'h18
`define DSM_ACTMODE_OFS   8'h1C
`define DSM_RUN_BIT       0
`define DSM_REV_BIT       1
`define DSM_EXC_BIT       2
`define DSM_QS_BIT        3
`define DSM_HALT_BIT      4
`define DSM_LOCK_BIT      5
`define DSM_ST_ATT_BIT    0
`define DSM_ST_RDY_BIT    1
`define DSM_ST_QS_BIT     2
`define DSM_MODE_SPEED    16'h0000
`define DSM_SPEED_COMMAND_MAX      16'hEA60
`define DSM_ACCEL_RST     16'h000A
`define DSM_DECEL_RST     16'h000A
`define DSM_QS_PERIOD     32'h0000_0000
`define DSM_CLK_NS        4
`define DSM_EXC_TIME_NS   1000
`define DSM_EXC_CYC       ((`DSM_EXC_TIME_NS + `DSM_CLK_NS - 1) / `DSM_CLK_NS)
`define DSM_TICK_NS       1000
`define DSM_TICK_CYC      (`DSM_TICK_NS / `DSM_CLK_NS)
`endif

/* rtl/dsm_pkg.sv */
// Types shared by the speed-mode control design
// Assumes dsm_defs.svh is on the include path
package dsm_pkg;
  typedef logic [15:0] dsm_word_t;
  typedef logic [31:0] dsm_data_t;
  // Excitation state, Gray coded along off -> exciting -> ready
  typedef enum logic [1:0] {
    DSM_OFF      = 2'b00,
    DSM_EXCITING = 2'b01,
    DSM_READY    = 2'b11
  } dsm_exc_e;
endpackage

/* rtl/dsm_ramp.sv */
// Frequency ramp: one 0.01 Hz step toward a goal every period+1 cycles
// Assumes goal, period and controls come from logic on the same clock
`timescale 1ns/10ps
`include "dsm_defs.svh"
module dsm_ramp #(
  parameter int W = 16
) (
  input  wire logic         pclk,     // Clock
  input  wire logic         presetn,  // Async reset, active low
  input  wire logic [W-1:0] goal,     // Frequency to move toward
  input  wire logic [31:0]  period,   // Cycles between steps, minus one
  input  wire logic         hold,     // Freeze frequency
  input  wire logic         zero_now, // Force frequency to zero at once
  output logic      [W-1:0] speed_command      // Present frequency
);
  import dsm_pkg::*;

  logic [31:0] cnt;
  logic        at_goal;
  logic        step;

  if (W < 2) begin : g_width_check
    $error("dsm_ramp: width too small");
  end

  assign at_goal = (speed_command == goal);
  assign step    = !zero_now && !hold && !at_goal && (cnt >= period);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 32'h0000_0000;
    end else if (zero_now || hold || at_goal || step) begin
      cnt <= 32'h0000_0000;
    end else begin
      cnt <= cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_command <= '0;
    end else if (zero_now) begin
      speed_command <= '0;
    end else if (step) begin
      if (speed_command < goal) begin
        speed_command <= speed_command + W'(1);
      end else begin
        speed_command <= speed_command - W'(1);
      end
    end
  end
endmodule

/* testbench/dsm_ctrl_monitor.sv */
// Checker for the speed-mode control block
// Sees only the top ports; shadows control and mode writes itself
`timescale 1ns/10ps
module dsm_ctrl_monitor #(
  parameter int EXC_CYC  = 250, // Excitation cycles
  parameter int TICK_CYC = 250  // Ramp tick cycles
) (
  input wire logic               pclk,          // Clock
  input wire logic               presetn,       // Reset, active low
  input wire logic               psel,          // APB select
  input wire logic               penable,       // APB access
  input wire logic               pwrite,        // APB write
  input wire logic [7:0]         paddr,         // APB address
  input wire dsm_pkg::dsm_data_t pwdata,        // APB write data
  input wire dsm_pkg::dsm_data_t prdata,        // APB read data
  input wire logic               pready,        // APB ready
  input wire logic               pslverr,       // APB error
  input wire logic               motor_enable,  // Stage energised
  input wire logic               motor_reverse, // Reverse
  input wire dsm_pkg::dsm_word_t motor_speed_command     // Frequency
);
  import dsm_pkg::*;
  logic [5:0] ctrl_q;
  logic       mode_nz;
  logic [2:0] quiet;
  wire        wr_any  = psel && penable && pwrite;
  wire        wr_ctrl = wr_any && paddr == 8'h00;
  wire        settled = quiet > 3'h3;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= 6'h00;
    else if (wr_ctrl) ctrl_q <= pwdata[5:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_nz <= 1'b0;
    else if (wr_any && paddr == 8'h04) mode_nz <= |pwdata[15:0];
  end
  // Cycles since the last write, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet <= 3'h0;
    else if (wr_any) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  a_speed_command_range: assert property (motor_speed_command <= 16'hEA60)
    else $error("frequency above range");
  a_step_size: assert property (motor_enable |=> !motor_enable ||
    (motor_speed_command - $past(motor_speed_command) + 16'h0001) <= 16'h0002)
    else $error("frequency jumped while energised");
  a_zero_unexcited: assert property (!ctrl_q[2] && settled |-> motor_speed_command == 16'h0000)
    else $error("frequency without excitation");
  a_enable_follows: assert property (wr_ctrl |-> ##3 motor_enable == $past(pwdata[2], 3))
    else $error("enable does not follow excite");
  a_dir_follows: assert property (wr_ctrl |-> ##2 motor_reverse == $past(pwdata[1], 2))
    else $error("direction does not follow");
  a_qs_decel: assert property (ctrl_q[2] && ctrl_q[3] && !mode_nz && settled
    && motor_speed_command != 16'h0000 |=> motor_speed_command == $past(motor_speed_command) - 16'h0001)
    else $error("quick stop not one step per cycle");
  a_lock_hold: assert property ((ctrl_q & 6'h3D) == 6'h25 && !mode_nz && settled
    |=> $stable(motor_speed_command))
    else $error("locked frequency moved");
  a_stop_decel: assert property (ctrl_q[2] && (!ctrl_q[0] || ctrl_q[4]) && settled
    |=> motor_speed_command <= $past(motor_speed_command))
    else $error("frequency rose while stopping");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
    else $error("unmapped access without error");
  c_quick: cover property (ctrl_q[3] && motor_speed_command != 16'h0000);
  c_excite: cover property (wr_ctrl && pwdata[2]);
  c_error: cover property (psel && penable && pslverr);
  c_mode: cover property (mode_nz && motor_speed_command != 16'h0000);
endmodule
bind dsm_ctrl dsm_ctrl_monitor #(.EXC_CYC(EXC_CYC), .TICK_CYC(TICK_CYC)) u_mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .motor_enable, .motor_reverse, .motor_speed_command);

/* testbench/dsm_motor_model.sv */
// Behavioural power stage and motor for the speed-mode bench
// Assumes the control block's motor outputs on the same clock
`timescale 1ns/10ps
module dsm_motor_model (
  input wire logic               pclk,          // Clock
  input wire logic               presetn,       // Reset, active low
  input wire logic               motor_enable,  // Stage energised
  input wire logic               motor_reverse, // Reverse rotation
  input wire dsm_pkg::dsm_word_t motor_speed_command,    // Frequency
  output logic signed [31:0]     angle,         // Signed travel
  output logic                   idle_spin      // Spin seen unexcited
);
  import dsm_pkg::*;
  logic               en_q;
  logic signed [31:0] f;
  assign f = {16'h0000, motor_speed_command};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      angle <= 0;
      en_q <= 1'b0;
      idle_spin <= 1'b0;
    end else begin
      en_q <= motor_enable;
      if (motor_enable) angle <= motor_reverse ? angle - f : angle + f;
      if (!motor_enable && !en_q && f != 0) idle_spin <= 1'b1;
    end
  end
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the speed-mode control block
// Assumes dsm_pkg compiled first; APB master tasks reach the registers
`timescale 1ns/10ps
module testbench;
  import dsm_pkg::*;
  localparam dsm_data_t TGT = 32'h14, TGT2 = 32'h28;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  dsm_data_t pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, motor_enable, motor_reverse, idle_spin, rerr;
  dsm_word_t motor_speed_command;
  logic signed [31:0] angle;
  int n_errors = 0, n_compared = 0;
  always #2 pclk = ~pclk;
  dsm_ctrl #(.EXC_CYC(4), .TICK_CYC(1)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .motor_enable, .motor_reverse, .motor_speed_command);
  dsm_motor_model mot (.pclk, .presetn, .motor_enable, .motor_reverse, .motor_speed_command,
    .angle, .idle_spin);
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input dsm_data_t d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input dsm_data_t e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  initial begin
    #40000;
    n_errors++;
    results();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h04, 32'h0);
    chk(rerr, 1'b0);
    rd(8'h1C, 32'h0);
    rd(8'h14, 32'h0);
    bus(1'b1, 8'h18, 32'h5);
    rd(8'h18, 32'h0);
    bus(1'b1, 8'h40, 32'h1);
    rd(8'h40, 32'h0);
    chk(rerr, 1'b1);
    bus(1'b1, 8'h08, 32'hFFFF);
    rd(8'h08, 32'hEA60);
    bus(1'b1, 8'h08, TGT);
    bus(1'b1, 8'h0C, 32'h1);
    bus(1'b1, 8'h10, 32'h2);
    bus(1'b1, 8'h00, 32'h31);
    cyc(10);
    rd(8'h18, 32'h0);
    chk(motor_enable, 1'b0);
    bus(1'b1, 8'h00, 32'h04);
    cyc(10);
    chk(motor_enable, 1'b1);
    rd(8'h18, 32'h0);
    rd(8'h14, 32'h2);
    bus(1'b1, 8'h00, 32'h05);
    cyc(40);
    rd(8'h18, TGT);
    rd(8'h14, 32'h3);
    chk(motor_speed_command, TGT);
    chk(angle > 0, 1'b1);
    bus(1'b1, 8'h00, 32'h25);
    bus(1'b1, 8'h08, TGT2);
    cyc(60);
    rd(8'h18, TGT);
    rd(8'h14, 32'h2);
    bus(1'b1, 8'h00, 32'h35);
    cyc(60);
    rd(8'h18, 32'h0);
    bus(1'b1, 8'h00, 32'h07);
    cyc(60);
    rd(8'h18, TGT2);
    chk(motor_reverse, 1'b1);
    bus(1'b1, 8'h00, 32'h3F);
    cyc(8);
    rd(8'h14, 32'h6);
    cyc(36);
    rd(8'h18, 32'h0);
    rd(8'h14, 32'h2);
    bus(1'b1, 8'h00, 32'h3B);
    cyc(5);
    rd(8'h14, 32'h0);
    chk(motor_enable, 1'b0);
    bus(1'b1, 8'h04, 32'h0);
    rd(8'h1C, 32'h0);
    chk(idle_spin, 1'b0);
    bus(1'b1, 8'h00, 32'h05);
    cyc(60);
    bus(1'b1, 8'h04, 32'h1);
    rd(8'h1C, 32'h1);
    cyc(100);
    rd(8'h18, 32'h0);
    rd(8'h14, 32'h2);
    bus(1'b1, 8'h04, 32'h0);
    cyc(20);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    chk(motor_speed_command, 16'h0000);
    results();
  end
endmodule
